//--- core/cut_ready_core.sv
// cut readiness, mark queue and post-cut gap control of a flying shear
// Behaviour
// - ready only while carriage inside tolerance window
// - window compared in raw carriage increments
// - window never reached: no cut, carriage runs on
// - n consecutive in-window cycles, 1..9999, before ready
// - cutting position compensated by tool width 0..999
// - mode 1 preset length, mode 2 per mark
// - mode 3 adds sub-cuts between marks
// - sensor distance used only in modes 2, 3
// - marks queued in 64-entry FIFO
// - cut on oldest mark, then advance queue
// - more than 64 queued marks gives error
// - after cut, brief acceleration makes a gap
// - gap width in length units, 0..9999
// - gap length zero disables gap
// - 1..9999 ms delay after sync speed
// - edge select picks cut-completed edge
// - gap formed within preset 1..9999 ms time
module cut_ready_core #(
	parameter int unsigned CYC_PER_MS = shear_pkg::CYC_PER_MS_DEF
) (
	input  wire logic                               mclk,
	input  wire logic                               rst_b,
	input  wire logic        [1:0]                  cut_mode,
	input  wire logic        [shear_pkg::POS_W-1:0] preset_len,
	input  wire logic        [shear_pkg::POS_W-1:0] sensor_dist,
	input  wire logic        [shear_pkg::TOOL_W-1:0] tool_width,
	input  wire logic        [shear_pkg::WIN_W-1:0] cut_window,
	input  wire logic        [shear_pkg::SET_W-1:0] sync_samples,
	input  wire logic        [shear_pkg::SET_W-1:0] sync_time_ms,
	input  wire logic                               edge_sel,
	input  wire logic        [shear_pkg::SET_W-1:0] gap_len,
	input  wire logic        [shear_pkg::SET_W-1:0] gap_time_ms,
	input  wire logic signed [shear_pkg::POS_W-1:0] line_pos,
	input  wire logic signed [shear_pkg::POS_W-1:0] carriage_pos,
	input  wire logic                               at_sync_speed,
	input  wire logic                               mark_in,
	input  wire logic                               cut_done_in,
	input  wire logic                               front_stop,
	input  wire logic                               err_clear,
	output logic                                    ready_to_cut,
	output logic             [shear_pkg::POS_W-1:0] cut_pos,
	output logic                                    gap_accel,
	output logic             [shear_pkg::SET_W-1:0] gap_width,
	output logic                                    gap_done,
	output logic                                    return_start,
	output logic                                    cut_missed,
	output logic                                    mark_error,
	output logic             [shear_pkg::CNT_W-1:0] mark_count
);
	import shear_pkg::*;

	typedef struct packed {
		cut_state_t       st;
		logic [SET_W-1:0] samp;
		logic             cd_prev;
		logic [POS_W-1:0] base;
		logic [POS_W-1:0] sub_off;
		logic [POS_W-1:0] cut_pos;
		logic [SET_W-1:0] gap_w;
		logic             ret;
		logic             gdone;
		logic             missed;
	} core_t;

	core_t             r;
	core_t             n;
	logic              print_mode;
	logic              push;
	logic              pop;
	logic              flush;
	logic              full;
	logic [POS_W-1:0]  head;
	logic [POS_W-1:0]  head2;
	logic [CNT_W-1:0]  count;
	logic [POS_W-1:0]  target_lu;
	logic              target_ok;
	logic [TOOL_W-1:0] tool_eff;
	logic [SET_W-1:0]  samp_eff;
	logic [SET_W-1:0]  gap_eff;
	logic signed [POS_W:0] diff;
	logic [POS_W:0]    abs_diff;
	logic signed [POS_W+1:0] pos_err;
	logic              in_win;
	logic              cnt_met;
	logic              cut_edge;
	logic              start_sync;
	logic              start_gap;
	logic              abort_sync;
	logic              sync_done;
	logic              gap_tmr_done;
	logic              adv;

	// only print-mark modes feed the queue; in mode 1 marks are ignored
	assign print_mode = (cut_mode == MODE_MARK) || (cut_mode == MODE_SUBCUT);
	assign push       = mark_in && print_mode && (r.st != ST_ERR);
	assign flush      = (r.st == ST_ERR) && err_clear;

	mark_fifo u_marks (
		.mclk  (mclk),
		.rst_b (rst_b),
		.push  (push),
		.pop   (pop),
		.flush (flush),
		.din   (line_pos),
		.head  (head),
		.head2 (head2),
		.count (count),
		.full  (full)
	);

	// settings outside their range are clamped rather than trusted
	assign tool_eff = (tool_width > TOOL_MAX) ? TOOL_MAX : tool_width;
	assign samp_eff = (sync_samples < SAMPLES_MIN) ? SAMPLES_MIN
		: ((sync_samples > SAMPLES_MAX) ? SAMPLES_MAX : sync_samples);
	assign gap_eff  = (gap_len > GAP_MAX) ? GAP_MAX : gap_len;

	// material position to cut at: oldest mark plus sensor distance, or next length
	assign target_lu = print_mode ? (head + sensor_dist + r.sub_off)
		: (r.base + preset_len);
	assign target_ok = !print_mode || (count != CNT_RST);

	// window is raw increments; the compare has one spare bit against wrap
	assign diff     = $signed({carriage_pos[POS_W-1], carriage_pos})
		- $signed({r.cut_pos[POS_W-1], r.cut_pos});
	assign abs_diff = diff[POS_W] ? (POS_W+1)'(-diff) : diff;
	assign in_win   = abs_diff <= {17'h0, cut_window};
	assign cnt_met  = r.samp >= samp_eff;

	// active edge of the cut-completed input
	assign cut_edge = (edge_sel == EDGE_RISE) ? (cut_done_in && !r.cd_prev)
		: (!cut_done_in && r.cd_prev);

	// both the settle delay and the sample filter must be satisfied
	assign ready_to_cut = (r.st == ST_CUT) && in_win && cnt_met && sync_done;

	ms_delay #(.CYC_PER_MS(CYC_PER_MS)) u_sync_tmr (
		.mclk   (mclk),
		.rst_b  (rst_b),
		.start  (start_sync),
		.abort  (abort_sync),
		.len_ms (sync_time_ms),
		.done   (sync_done)
	);

	ms_delay #(.CYC_PER_MS(CYC_PER_MS)) u_gap_tmr (
		.mclk   (mclk),
		.rst_b  (rst_b),
		.start  (start_gap),
		.abort  (1'b0),
		.len_ms (gap_time_ms),
		.done   (gap_tmr_done)
	);

	// sequence: idle, settle delay, cut window, optional gap; overflow overrides all
	always_comb begin
		n          = r;
		n.cd_prev  = cut_done_in;
		n.cut_pos  = line_pos - target_lu - {22'h0, tool_eff};
		n.ret      = 1'b0;
		n.gdone    = 1'b0;
		n.missed   = 1'b0;
		start_sync = 1'b0;
		start_gap  = 1'b0;
		abort_sync = 1'b0;
		adv        = 1'b0;
		pop        = 1'b0;
		unique case (r.st)
			ST_IDLE: begin
				if (at_sync_speed && target_ok) begin
					n.st       = ST_WAIT;
					n.samp     = SET_RST;
					start_sync = 1'b1;
				end
			end
			ST_WAIT: begin
				if (front_stop) begin
					n.st       = ST_IDLE;
					n.missed   = 1'b1;
					n.ret      = 1'b1;
					abort_sync = 1'b1;
					adv        = 1'b1;
				end else if (sync_done) begin
					n.st = ST_CUT;
				end
			end
			ST_CUT: begin
				// any cycle outside the window restarts the filter
				if (in_win) begin
					n.samp = (r.samp < SAMPLES_MAX) ? r.samp + 14'h1 : r.samp;
				end else begin
					n.samp = SET_RST;
				end
				if (cut_edge) begin
					adv        = 1'b1;
					abort_sync = 1'b1;
					if (gap_eff != SET_RST) begin
						n.st      = ST_GAP;
						n.gap_w   = gap_eff;
						start_gap = 1'b1;
					end else begin
						n.st  = ST_IDLE;
						n.ret = 1'b1;
					end
				end else if (front_stop) begin
					// window never met: give this piece up, no cut issued
					n.st       = ST_IDLE;
					n.missed   = 1'b1;
					n.ret      = 1'b1;
					abort_sync = 1'b1;
					adv        = 1'b1;
				end
			end
			ST_GAP: begin
				if (gap_tmr_done) begin
					n.st    = ST_IDLE;
					n.gdone = 1'b1;
					n.ret   = 1'b1;
				end
			end
			ST_ERR: begin
				if (err_clear) begin
					n.st      = ST_IDLE;
					n.sub_off = POS_RST;
				end
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase
		// move to the next cutting target once a piece is done or given up
		if (adv) begin
			if (!print_mode) begin
				n.base = r.base + preset_len;
			end else if ((cut_mode == MODE_SUBCUT) && ((count < 7'h2)
				|| (head + r.sub_off + preset_len < head2))) begin
				n.sub_off = r.sub_off + preset_len;
			end else begin
				pop       = 1'b1;
				n.sub_off = POS_RST;
			end
		end
		if (push && full) begin
			n.st = ST_ERR;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			r <= '{st: ST_IDLE, samp: SET_RST, cd_prev: 1'b0, base: POS_RST,
				sub_off: POS_RST, cut_pos: POS_RST, gap_w: SET_RST,
				ret: 1'b0, gdone: 1'b0, missed: 1'b0};
		end else begin
			r <= n;
		end
	end

	assign cut_pos      = r.cut_pos;
	assign gap_accel    = (r.st == ST_GAP);
	assign gap_width    = r.gap_w;
	assign gap_done     = r.gdone;
	assign return_start = r.ret;
	assign cut_missed   = r.missed;
	assign mark_error   = (r.st == ST_ERR);
	assign mark_count   = count;

	// checker view of the carriage error taken from the ports, compared two-sided
	assign pos_err = $signed({{2{carriage_pos[POS_W-1]}}, carriage_pos})
		- $signed({{2{cut_pos[POS_W-1]}}, cut_pos});

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	a_ready_in_window: assert property (ready_to_cut |->
		(pos_err <= $signed({18'h0, cut_window})) && (pos_err >= -$signed({18'h0, cut_window})))
		else $error("ready asserted outside cut window");
	a_ready_samples: assert property (ready_to_cut |-> $past(in_win) && r.samp >= samp_eff)
		else $error("ready asserted before sample filter met");
	a_ready_delay: assert property (ready_to_cut |->
		$past(r.st) == ST_CUT && $past(sync_done))
		else $error("ready asserted before sync delay expired");
	a_no_cut_front: assert property ((r.st == ST_CUT && front_stop && !cut_edge
		&& !(push && full)) |=> r.st == ST_IDLE && cut_missed && !ready_to_cut)
		else $error("front stop did not end the cut attempt");
	a_mark_overflow: assert property ((push && full) |=> mark_error)
		else $error("mark overflow did not raise error");
	a_gap_disabled: assert property ((r.st == ST_CUT && cut_edge && gap_eff == SET_RST
		&& !(push && full)) |=> !gap_accel ##1 !gap_accel)
		else $error("gap started with zero gap length");
	a_gap_started: assert property ((r.st == ST_CUT && cut_edge && gap_eff != SET_RST
		&& !(push && full)) |=> gap_accel && gap_width == $past(gap_eff))
		else $error("gap not started after cut");
	a_length_mode_queue: assert property (cut_mode == MODE_LENGTH |-> !push)
		else $error("mark queued in length mode");
	a_mark_pop_cut: assert property ((r.st == ST_CUT && cut_edge && cut_mode == MODE_MARK
		&& count != CNT_RST) |=> mark_count == $past(mark_count) - 7'h1 + 7'($past(push)))
		else $error("queue did not advance after cut");
	a_sync_delay: assert property ($rose(r.st == ST_WAIT) |-> !sync_done [*2])
		else $error("sync delay ended too early");

	c_ready:    cover property (ready_to_cut);
	c_gap_done: cover property (gap_done);
	c_overflow: cover property (push && full);
	c_missed:   cover property (cut_missed);
endmodule

//--- pkg/shear_pkg.sv
// constants, state encoding and limits shared by the cut readiness logic
package shear_pkg;
	localparam int unsigned POS_W          = 32;
	localparam int unsigned SET_W          = 14;
	localparam int unsigned TOOL_W         = 10;
	localparam int unsigned WIN_W          = 16;
	localparam int unsigned FIFO_DEPTH     = 64;
	localparam int unsigned FIFO_AW        = 6;
	localparam int unsigned CNT_W          = 7;
	localparam int unsigned PRE_W          = 16;
	localparam int unsigned CLK_PERIOD_NS  = 20;
	localparam int unsigned MS_NS          = 1000000;
	localparam int unsigned CYC_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;

	// setting limits
	localparam logic [SET_W-1:0]  SAMPLES_MIN = 14'h0001;
	localparam logic [SET_W-1:0]  SAMPLES_MAX = 14'h270f;
	localparam logic [SET_W-1:0]  MS_MIN      = 14'h0001;
	localparam logic [SET_W-1:0]  MS_MAX      = 14'h270f;
	localparam logic [SET_W-1:0]  GAP_MAX     = 14'h270f;
	localparam logic [TOOL_W-1:0] TOOL_MAX    = 10'h3e7;
	localparam logic [CNT_W-1:0]  FIFO_FULL   = 7'h40;

	// cutting modes
	localparam logic [1:0] MODE_LENGTH = 2'h1;
	localparam logic [1:0] MODE_MARK   = 2'h2;
	localparam logic [1:0] MODE_SUBCUT = 2'h3;

	// cut-completed edge select
	localparam logic EDGE_RISE = 1'h0;

	// values after reset
	localparam logic [POS_W-1:0]   POS_RST = 32'h0;
	localparam logic [SET_W-1:0]   SET_RST = 14'h0;
	localparam logic [PRE_W-1:0]   PRE_RST = 16'h0;
	localparam logic [FIFO_AW-1:0] PTR_RST = 6'h0;
	localparam logic [CNT_W-1:0]   CNT_RST = 7'h0;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_WAIT = 3'h1,
		ST_CUT  = 3'h3,
		ST_GAP  = 3'h2,
		ST_ERR  = 3'h6
	} cut_state_t;
endpackage

//--- core/ms_delay.sv
// millisecond delay timer with a cycle prescaler, clamped to 1..9999 ms
module ms_delay #(
	parameter int unsigned CYC_PER_MS = shear_pkg::CYC_PER_MS_DEF
) (
	input  wire logic                        mclk,
	input  wire logic                        rst_b,
	input  wire logic                        start,
	input  wire logic                        abort,
	input  wire logic [shear_pkg::SET_W-1:0] len_ms,
	output logic                             done
);
	import shear_pkg::*;

	typedef struct packed {
		logic             busy;
		logic             done;
		logic [SET_W-1:0] ms;
		logic [PRE_W-1:0] pre;
	} tmr_t;

	tmr_t r;
	tmr_t n;
	logic [SET_W-1:0] len_eff;

	// zero would mean no delay at all, so it is held at the minimum
	always_comb begin
		len_eff = (len_ms < MS_MIN) ? MS_MIN : ((len_ms > MS_MAX) ? MS_MAX : len_ms);
		n = r;
		if (abort) begin
			n.busy = 1'b0;
			n.done = 1'b0;
		end else if (start) begin
			n.busy = 1'b1;
			n.done = 1'b0;
			n.ms   = len_eff;
			n.pre  = PRE_RST;
		end else if (r.busy) begin
			if (r.pre == PRE_W'(CYC_PER_MS - 1)) begin
				n.pre = PRE_RST;
				n.ms  = r.ms - 14'h1;
				if (r.ms == MS_MIN) begin
					n.busy = 1'b0;
					n.done = 1'b1;
				end
			end else begin
				n.pre = r.pre + 16'h1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			r <= '{busy: 1'b0, done: 1'b0, ms: SET_RST, pre: PRE_RST};
		end else begin
			r <= n;
		end
	end

	assign done = r.done;
endmodule

//--- core/mark_fifo.sv
// 64-entry queue of print-mark line positions, oldest entry at the head
module mark_fifo (
	input  wire logic                        mclk,
	input  wire logic                        rst_b,
	input  wire logic                        push,
	input  wire logic                        pop,
	input  wire logic                        flush,
	input  wire logic [shear_pkg::POS_W-1:0] din,
	output logic      [shear_pkg::POS_W-1:0] head,
	output logic      [shear_pkg::POS_W-1:0] head2,
	output logic      [shear_pkg::CNT_W-1:0] count,
	output logic                             full
);
	import shear_pkg::*;

	typedef struct packed {
		logic [FIFO_DEPTH-1:0][POS_W-1:0] mem;
		logic [FIFO_AW-1:0]               wp;
		logic [FIFO_AW-1:0]               rp;
		logic [CNT_W-1:0]                 cnt;
	} fifo_t;

	fifo_t r;
	fifo_t n;
	logic  do_push;
	logic  do_pop;

	// a push into a full queue is dropped here; the core flags it as an error
	always_comb begin
		do_push = push && (r.cnt != FIFO_FULL);
		do_pop  = pop && (r.cnt != CNT_RST);
		n = r;
		if (flush) begin
			n.wp  = PTR_RST;
			n.rp  = PTR_RST;
			n.cnt = CNT_RST;
		end else begin
			if (do_push) begin
				n.mem[r.wp] = din;
				n.wp        = r.wp + 6'h1;
			end
			if (do_pop) begin
				n.rp = r.rp + 6'h1;
			end
			n.cnt = r.cnt + CNT_W'(do_push) - CNT_W'(do_pop);
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			r <= '{mem: '0, wp: PTR_RST, rp: PTR_RST, cnt: CNT_RST};
		end else begin
			r <= n;
		end
	end

	assign head  = r.mem[r.rp];
	assign head2 = r.mem[r.rp + 6'h1];
	assign count = r.cnt;
	assign full  = (r.cnt == FIFO_FULL);
endmodule

//--- testbench/carriage_model.sv
// carriage drive and encoder model: material runs on, carriage tracks the cut point
module carriage_model (
	input  wire logic                               mclk,
	input  wire logic                               rst_b,
	input  wire logic        [shear_pkg::POS_W-1:0] cut_pos,
	input  wire logic signed [shear_pkg::POS_W-1:0] track_err,
	output logic signed      [shear_pkg::POS_W-1:0] line_pos,
	output logic signed      [shear_pkg::POS_W-1:0] carriage_pos
);
	timeunit 1ns;
	timeprecision 1ps;
	import shear_pkg::*;
	// material advances one increment a cycle, so the cut point keeps moving
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			line_pos <= '0;
		end else begin
			line_pos <= line_pos + 32'sh1;
		end
	end
	// carriage follows the cut point with a bench-set error, in raw increments
	assign carriage_pos = $signed(cut_pos) + track_err;
endmodule

//--- testbench/cut_readiness_and_mark_queue_tb.sv
// self-checking bench for the cut readiness and mark queue logic
module cut_readiness_and_mark_queue_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import shear_pkg::*;
	localparam int CPM = 4;
	logic                    mclk, rst_b, edge_sel, at_sync_speed, mark_in, cut_done_in;
	logic                    front_stop, err_clear, ready_to_cut, gap_accel, gap_done;
	logic                    return_start, cut_missed, mark_error;
	logic [1:0]              cut_mode;
	logic [POS_W-1:0]        preset_len, sensor_dist, cut_pos, m0, m1, t0;
	logic [TOOL_W-1:0]       tool_width;
	logic [WIN_W-1:0]        cut_window;
	logic [SET_W-1:0]        sync_samples, sync_time_ms, gap_len, gap_time_ms, gap_width;
	logic signed [POS_W-1:0] line_pos, carriage_pos, track_err;
	logic [CNT_W-1:0]        mark_count;
	int                      errors, comparisons;

	cut_ready_core #(.CYC_PER_MS(CPM)) u_dut (
		.mclk(mclk), .rst_b(rst_b), .cut_mode(cut_mode), .preset_len(preset_len),
		.sensor_dist(sensor_dist), .tool_width(tool_width), .cut_window(cut_window),
		.sync_samples(sync_samples), .sync_time_ms(sync_time_ms), .edge_sel(edge_sel),
		.gap_len(gap_len), .gap_time_ms(gap_time_ms), .line_pos(line_pos),
		.carriage_pos(carriage_pos), .at_sync_speed(at_sync_speed), .mark_in(mark_in),
		.cut_done_in(cut_done_in), .front_stop(front_stop), .err_clear(err_clear),
		.ready_to_cut(ready_to_cut), .cut_pos(cut_pos), .gap_accel(gap_accel),
		.gap_width(gap_width), .gap_done(gap_done), .return_start(return_start),
		.cut_missed(cut_missed), .mark_error(mark_error), .mark_count(mark_count)
	);
	carriage_model u_carriage (
		.mclk(mclk), .rst_b(rst_b), .cut_pos(cut_pos), .track_err(track_err),
		.line_pos(line_pos), .carriage_pos(carriage_pos)
	);

	// free-running 50 MHz clock
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task automatic end_of_test();
		if (errors == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic pick(input int sel);
		case (sel)
			0: return ready_to_cut;
			1: return return_start;
			2: return cut_missed;
			3: return gap_done;
			default: return gap_accel;
		endcase
	endfunction

	// target plus tool width as seen through the registered cut point
	function automatic logic [POS_W-1:0] tgt();
		return line_pos - 32'sh1 - $signed(cut_pos);
	endfunction

	// bounded wait for one output; a spent bound ends the run
	task automatic wait_for(input int sel, input int lim, output int n);
		n = 0;
		while (pick(sel) !== 1'b1) begin
			@(posedge mclk);
			#1;
			n++;
			if (n > lim) begin
				errors++;
				$display("BAD wait %0d expected 1 seen 0", sel);
				end_of_test();
			end
		end
	endtask

	task automatic quiet(input int sel, input int k);
		repeat (k) begin
			@(posedge mclk);
			#1;
			chk("quiet output", 0, pick(sel));
		end
	endtask

	// mark pulse; the queued entry is the line position sampled with it
	task automatic push_mark(output logic [POS_W-1:0] pos);
		@(posedge mclk);
		mark_in <= 1'b1;
		#1;
		pos = line_pos;
		@(posedge mclk);
		mark_in <= 1'b0;
		#1;
	endtask

	task automatic run_to_ready(input int n_samp);
		int n;
		@(posedge mclk);
		at_sync_speed <= 1'b1;
		#1;
		wait_for(0, 200, n);
		chk("ready delay", 1, n >= sync_time_ms * CPM + n_samp);
	endtask

	// speed request drops with the ending edge so no new piece starts behind it
	task automatic end_cut(input bit gap);
		int n;
		if (edge_sel) begin
			@(posedge mclk);
			cut_done_in <= 1'b1;
			#1;
			quiet(1, 3);
			chk("ready kept", 1, ready_to_cut);
		end
		@(posedge mclk);
		cut_done_in <= ~edge_sel;
		at_sync_speed <= 1'b0;
		#1;
		if (gap) begin
			wait_for(4, 4, n);
			chk("gap width", 32'h270f, gap_width);
			wait_for(3, gap_time_ms * CPM + 6, n);
			chk("gap time", 1, n >= gap_time_ms * CPM - 1);
			chk("return after gap", 1, return_start);
		end else begin
			wait_for(1, 4, n);
			chk("no gap", 0, gap_accel);
		end
		@(posedge mclk);
		cut_done_in <= 1'b0;
		#1;
	endtask

	task automatic t_reset();
		chk("ready", 0, ready_to_cut);
		chk("count", 0, mark_count);
		chk("error", 0, mark_error);
		chk("cut pos", 0, cut_pos);
		chk("pulses", 0, {gap_accel, gap_done, return_start, cut_missed});
	endtask

	task automatic t_length();
		int n;
		repeat (3) @(posedge mclk);
		#1;
		chk("target", preset_len + 32'h3e7, tgt());
		run_to_ready(3);
		@(posedge mclk);
		track_err <= 32'sh5;
		#1;
		chk("ready off window", 0, ready_to_cut);
		@(posedge mclk);
		track_err <= -32'sh4;
		#1;
		wait_for(0, 8, n);
		end_cut(0);
		chk("next target", 32'h190 + 32'h3e7, tgt());
		push_mark(m0);
		chk("marks in length mode", 0, mark_count);
	endtask

	// carriage never reaches the window: no ready, front stop abandons the piece
	task automatic t_miss();
		int n;
		t0 = tgt();
		@(posedge mclk);
		track_err <= 32'sh5;
		at_sync_speed <= 1'b1;
		#1;
		quiet(0, 40);
		@(posedge mclk);
		front_stop <= 1'b1;
		at_sync_speed <= 1'b0;
		#1;
		wait_for(2, 4, n);
		chk("return on miss", 1, return_start);
		@(posedge mclk);
		front_stop <= 1'b0;
		track_err <= 32'sh0;
		repeat (2) @(posedge mclk);
		#1;
		chk("target after miss", t0 + preset_len, tgt());
		// front stop while the settle delay still runs also gives the piece up
		@(posedge mclk);
		at_sync_speed <= 1'b1;
		repeat (3) @(posedge mclk);
		front_stop <= 1'b1;
		at_sync_speed <= 1'b0;
		#1;
		wait_for(2, 4, n);
		chk("ready on early stop", 0, ready_to_cut);
		@(posedge mclk);
		front_stop <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		chk("target after early stop", t0 + 32'h190, tgt());
	endtask

	task automatic t_marks();
		@(posedge mclk);
		cut_mode <= MODE_MARK;
		edge_sel <= 1'b1;
		tool_width <= '0;
		sync_samples <= 14'h1;
		push_mark(m0);
		repeat (20) @(posedge mclk);
		push_mark(m1);
		chk("count", 2, mark_count);
		chk("mark target", m0 + sensor_dist, tgt());
		run_to_ready(1);
		end_cut(0);
		chk("count after cut", 1, mark_count);
		chk("next mark target", m1 + sensor_dist, tgt());
	endtask

	task automatic t_overflow();
		@(posedge mclk);
		mark_in <= 1'b1;
		repeat (63) @(posedge mclk);
		mark_in <= 1'b0;
		#1;
		chk("full count", 32'h40, mark_count);
		chk("no error at full", 0, mark_error);
		push_mark(m0);
		chk("overflow error", 1, mark_error);
		@(posedge mclk);
		err_clear <= 1'b1;
		@(posedge mclk);
		err_clear <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		chk("error cleared", 0, mark_error);
		chk("queue emptied", 0, mark_count);
	endtask

	// two marks far apart: a sub-cut keeps the mark and steps by the preset length
	task automatic t_subcut();
		@(posedge mclk);
		cut_mode <= MODE_SUBCUT;
		preset_len <= 32'ha;
		sensor_dist <= '0;
		gap_len <= 14'h3fff;
		edge_sel <= 1'b0;
		push_mark(m0);
		repeat (40) @(posedge mclk);
		push_mark(m1);
		chk("first sub-cut target", m0, tgt());
		run_to_ready(1);
		end_cut(1);
		chk("marks kept", 2, mark_count);
		chk("sub-cut target", m0 + 32'ha, tgt());
	endtask

	initial begin
		errors = 0;
		comparisons = 0;
		rst_b = 1'b0;
		cut_mode = MODE_LENGTH;
		preset_len = 32'hc8;
		sensor_dist = 32'h3e8;
		tool_width = 10'h3ff;
		cut_window = 16'h4;
		sync_samples = 14'h3;
		sync_time_ms = 14'h2;
		edge_sel = 1'b0;
		gap_len = 14'h0;
		gap_time_ms = 14'h1;
		track_err = 32'sh0;
		at_sync_speed = 1'b0;
		mark_in = 1'b0;
		cut_done_in = 1'b0;
		front_stop = 1'b0;
		err_clear = 1'b0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		#1;
		t_reset();
		t_length();
		t_miss();
		t_marks();
		t_overflow();
		t_subcut();
		end_of_test();
	end
endmodule
